// >>> verilog/burst_delay_map.svh
`ifndef BURST_DELAY_MAP_SVH
`define BURST_DELAY_MAP_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define CFG_OFS 8'h00
`define STAT_OFS 8'h04
// ----------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------
`define RM_BIT 15
`define DELAY_MSB 13
`define DELAY_LSB 10
`define HOLD_BIT 9
`define EDGE_BIT 6
// ----------------------------------------------------------------
// Reset values and delay decode
// ----------------------------------------------------------------
`define RM_RST 1'b1
`define DELAY_RST 4'h7
`define DELAY_MAX 4'h7
`define DELAY_BASE 4'h2
`define EDGE_RISING 1'b1
`define HOLD_ONE 1'b0
`define CNT_LAST 4'h1
`define WORDS_MAX 8'hff
// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define STAT_STATE_MSB 1
`define STAT_STATE_LSB 0
`define STAT_FIFO_BIT 2
`define STAT_DRIVE_BIT 3
`define STAT_CNT_MSB 7
`define STAT_CNT_LSB 4
`define STAT_WORDS_MSB 15
`define STAT_WORDS_LSB 8
`endif

// >>> verilog/burst_delay_pkg.sv
package burst_delay_pkg;
  // Burst sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_BURST,
    ST_HOLD
  } state_t;
endpackage : burst_delay_pkg

// >>> verilog/burst_word_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Word FIFO between the array output path and the data lines
// ----------------------------------------------------------------
module burst_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock, reset, enable, flush
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic flush_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW:0] ONE = (PW+1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] next_rd;
  logic [PW:0] count;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  // Handshakes use the registered flags, so full and empty are honest
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign next_rd = !pop ? rd_ptr :
                   (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);

  // Head word comes from a register; a push into an emptying FIFO is
  // the next head, so it bypasses the storage it is written into.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_data_o <= '0;
    end else if (en_i) begin
      out_data_o <= (push && wr_ptr == next_rd) ? in_data_i : mem[next_rd];
    end
  end

  // Occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + ONE;
    end else if (pop && !push) begin
      next_count = count - ONE;
    end
  end

  // Storage; no reset needed on the data words
  always_ff @(posedge clk_i) begin
    if (en_i && push && !flush_i) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and flags; flush drops everything held
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else if (en_i) begin
      if (flush_i) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
        in_ready_o <= 1'b1;
        out_valid_o <= 1'b0;
      end else begin
        if (push) begin
          wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
        end
        if (pop) begin
          rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
        end
        count <= next_count;
        in_ready_o <= (next_count != FULL);
        out_valid_o <= (next_count != '0);
      end
    end
  end
endmodule : burst_word_fifo

// >>> verilog/burst_read_initial_delay_ctrl.sv
// Operation
// - Asynchronous reads ignore the initial delay; it applies to bursts only.
// - Delay is counted in clocks from the start edge to first valid data.
// - Burst starts, address taken, on first low-strobe edge or strobe rise.
// - Delay field decodes as binary; codes zero to seven give two to nine.
// - Every burst word is launched on a rising clock edge.
// - Clock edge select bit six reads one always, selecting rising edge.
// - Each burst word stands on the data lines for exactly one clock; here the lines keep the last word, valid low, until the next launch.
// - Reset during a burst ends it and returns to asynchronous reads.
// - Read mode bit resets to one; writing zero enables burst reads.
// - Delay field resets to binary 0111, a nine clock delay.
// - Chip enable high leaves the burst and floats the data lines.
`timescale 1ns/1ps
`include "burst_delay_map.svh"
module burst_read_initial_delay_ctrl #(
  parameter int AW = 24,
  parameter int DW = 32,
  parameter int FIFO_DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // Host strobes and address
  input wire logic CHIP_EN_N_I,
  input wire logic ADDRESS_VALID_STROBE_N_I,
  input wire logic [AW-1:0] ADDR_I,
  // Data lines toward the host
  output logic [DW-1:0] DATA_LINES_O,
  output logic DATA_LINES_OE_N_O,
  output logic DATA_VALID_O,
  // Array output path
  output logic ARRAY_REQ_O,
  output logic [AW-1:0] ARRAY_ADDR_O,
  input wire logic [DW-1:0] ARRAY_DATA_I,
  input wire logic ARRAY_VALID_I,
  output logic ARRAY_READY_O,
  // Status
  output burst_delay_pkg::state_t BURST_STATE_O
);
  import burst_delay_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_t state;
  logic read_mode_select;
  logic [3:0] initial_delay_field;
  logic [3:0] delay_cnt;
  logic [3:0] delay_cycles;
  logic [7:0] words_sent;
  logic strobe_low_q;
  logic strobe_rise;
  logic start;
  logic ce_off;
  logic fifo_flush;
  logic fifo_in_ready;
  logic [DW-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic launch;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // Start detection
  // ----------------------------------------------------------------
  // A rise only starts a burst when no low level was seen on an edge
  // with chip enable active; in the synchronous sampling used here
  // that covers a strobe pulse that ends just as chip enable falls.
  assign ce_off = CHIP_EN_N_I;
  assign strobe_rise = strobe_low_q & ADDRESS_VALID_STROBE_N_I;
  assign start = !ce_off &&
                 (!ADDRESS_VALID_STROBE_N_I ||
                  (strobe_rise && state == ST_IDLE));

  // Strobe history for the rising edge; low seen outside a burst only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      strobe_low_q <= 1'b0;
    end else if (CLK_EN_I) begin
      strobe_low_q <= !ADDRESS_VALID_STROBE_N_I && ce_off;
    end
  end

  // ----------------------------------------------------------------
  // Delay decode
  // ----------------------------------------------------------------
  // Field value plus two; the field never holds more than seven
  assign delay_cycles = initial_delay_field + `DELAY_BASE;

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  // A new start always restarts, dropping the old address's words
  assign fifo_flush = start || ce_off;
  assign fifo_pop = launch;

  // A word leaves the FIFO when the sequencer may show one this edge
  always_comb begin
    launch = 1'b0;
    if (!start && !ce_off && fifo_valid) begin
      unique case (state)
        ST_DELAY: launch = (delay_cnt == `CNT_LAST);
        ST_BURST: launch = 1'b1;
        ST_HOLD: launch = (words_sent == 8'h00);
        ST_IDLE: launch = 1'b0;
      endcase
    end
  end

  // State; reset is asynchronous so a burst ends at once
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
    end else if (CLK_EN_I) begin
      if (ce_off) begin
        state <= ST_IDLE;
      end else if (start) begin
        // Asynchronous mode skips the delay entirely
        state <= read_mode_select ? ST_HOLD : ST_DELAY;
      end else if (state == ST_DELAY && delay_cnt == `CNT_LAST &&
                   fifo_valid) begin
        state <= ST_BURST;
      end
    end
  end

  // Delay counter: loaded on the start edge, first word at edge N
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      delay_cnt <= 4'h0;
    end else if (CLK_EN_I) begin
      if (start) begin
        delay_cnt <= delay_cycles;
      end else if (state == ST_DELAY && delay_cnt != `CNT_LAST) begin
        delay_cnt <= delay_cnt - 4'h1;
      end
    end
  end

  // Words launched since the start, saturating
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      words_sent <= 8'h00;
    end else if (CLK_EN_I) begin
      if (start || ce_off) begin
        words_sent <= 8'h00;
      end else if (launch && words_sent != `WORDS_MAX) begin
        words_sent <= words_sent + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Array request
  // ----------------------------------------------------------------
  // One-cycle request with the latched address on every start
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ARRAY_REQ_O <= 1'b0;
      ARRAY_ADDR_O <= '0;
    end else if (CLK_EN_I) begin
      ARRAY_REQ_O <= start;
      if (start) begin
        ARRAY_ADDR_O <= ADDR_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data lines
  // ----------------------------------------------------------------
  // Words change only at rising edges; valid lasts one clock in a
  // burst, so a late array shows as a gap, never as a stretched word.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DATA_LINES_O <= '0;
      DATA_VALID_O <= 1'b0;
    end else if (CLK_EN_I) begin
      if (launch) begin
        DATA_LINES_O <= fifo_data;
      end
      if (state == ST_HOLD && !start && !ce_off) begin
        DATA_VALID_O <= launch || (words_sent != 8'h00);
      end else begin
        DATA_VALID_O <= launch;
      end
    end
  end

  // Drive enable, low while driving; floats on chip enable or reset
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DATA_LINES_OE_N_O <= 1'b1;
    end else if (CLK_EN_I) begin
      if (ce_off || start) begin
        DATA_LINES_OE_N_O <= 1'b1;
      end else if (launch) begin
        DATA_LINES_OE_N_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Reset restores asynchronous mode and the nine clock delay
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      read_mode_select <= `RM_RST;
    end else if (CLK_EN_I) begin
      if (REG_WR_I && REG_ADDR_I == `CFG_OFS) begin
        read_mode_select <= REG_WDATA_I[`RM_BIT];
      end
    end
  end

  // Unsupported codes are dropped so the delay is never undefined
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      initial_delay_field <= `DELAY_RST;
    end else if (CLK_EN_I) begin
      if (REG_WR_I && REG_ADDR_I == `CFG_OFS &&
          REG_WDATA_I[`DELAY_MSB:`DELAY_LSB] <= `DELAY_MAX) begin
        initial_delay_field <=
          REG_WDATA_I[`DELAY_MSB:`DELAY_LSB];
      end
    end
  end

  // Read images; edge select and data hold are fixed, not stored
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`RM_BIT] = read_mode_select;
    cfg_word[`DELAY_MSB:`DELAY_LSB] = initial_delay_field;
    cfg_word[`HOLD_BIT] = `HOLD_ONE;
    cfg_word[`EDGE_BIT] = `EDGE_RISING;
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`STAT_STATE_MSB:`STAT_STATE_LSB] = state;
    stat_word[`STAT_FIFO_BIT] = fifo_valid;
    stat_word[`STAT_DRIVE_BIT] = !DATA_LINES_OE_N_O;
    stat_word[`STAT_CNT_MSB:`STAT_CNT_LSB] = delay_cnt;
    stat_word[`STAT_WORDS_MSB:`STAT_WORDS_LSB] = words_sent;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `CFG_OFS: next_rdata = cfg_word;
        `STAT_OFS: next_rdata = stat_word;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (CLK_EN_I) begin
      REG_RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Word FIFO and status outputs
  // ----------------------------------------------------------------
  burst_word_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) burst_word_fifo_i (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .en_i(CLK_EN_I),
    .flush_i(fifo_flush),
    .in_data_i(ARRAY_DATA_I),
    .in_valid_i(ARRAY_VALID_I),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // Ready is a flop inside the FIFO; state is the sequencer flop
  assign ARRAY_READY_O = fifo_in_ready;
  assign BURST_STATE_O = state;
endmodule : burst_read_initial_delay_ctrl

// >>> test/burst_ctrl_asserts.sv
`timescale 1ns/1ps
`include "burst_delay_map.svh"
// ------------------------------
// Port checker for the burst timing controller
// ------------------------------
module burst_ctrl_asserts #(
  parameter int AW = 24
) (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  // Host side
  input wire logic CHIP_EN_N_I,
  input wire logic ADDRESS_VALID_STROBE_N_I,
  input wire logic [AW-1:0] ADDR_I,
  input wire logic DATA_LINES_OE_N_O,
  input wire logic DATA_VALID_O,
  // Array side and status
  input wire logic ARRAY_REQ_O,
  input wire logic [AW-1:0] ARRAY_ADDR_O,
  input wire logic ARRAY_READY_O,
  input wire burst_delay_pkg::state_t BURST_STATE_O
);
  import burst_delay_pkg::*;
  logic wr_seen;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Remembers a config write, so default values are judged only before it
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_seen <= 1'b0;
    end else if (CLK_EN_I && REG_WR_I && REG_ADDR_I == `CFG_OFS) begin
      wr_seen <= 1'b1;
    end
  end
  sequence s_start;
    CLK_EN_I && !CHIP_EN_N_I && !ADDRESS_VALID_STROBE_N_I;
  endsequence
  sequence s_rd_cfg;
    CLK_EN_I && REG_RD_I && REG_ADDR_I == `CFG_OFS;
  endsequence
  property p_req;
    s_start |=> ARRAY_REQ_O && ARRAY_ADDR_O == $past(ADDR_I);
  endproperty
  property p_gap;
    s_start |=> !DATA_VALID_O && DATA_LINES_OE_N_O;
  endproperty
  property p_ce;
    CLK_EN_I && CHIP_EN_N_I |=> DATA_LINES_OE_N_O && !DATA_VALID_O
      && BURST_STATE_O == ST_IDLE;
  endproperty
  property p_float;
    DATA_VALID_O |-> !DATA_LINES_OE_N_O;
  endproperty
  property p_edge;
    s_rd_cfg |=> REG_RDATA_O[`EDGE_BIT] == `EDGE_RISING;
  endproperty
  property p_hold;
    s_rd_cfg |=> REG_RDATA_O[`HOLD_BIT] == `HOLD_ONE;
  endproperty
  property p_dflt;
    s_rd_cfg ##0 !wr_seen |=>
      REG_RDATA_O[`RM_BIT:`DELAY_LSB] == {`RM_RST, 1'b0, `DELAY_RST};
  endproperty
  property p_freeze;
    !CLK_EN_I |=> $stable(BURST_STATE_O) && $stable(DATA_VALID_O);
  endproperty
  // A start flushes old words, so the array may push at once
  property p_ready;
    s_start |=> ARRAY_READY_O;
  endproperty
  a_req: assert property (p_req)
    else $error("no fetch of start address");
  a_gap: assert property (p_gap)
    else $error("word too soon after start");
  a_ce: assert property (p_ce)
    else $error("burst kept with chip off");
  a_float: assert property (p_float)
    else $error("valid while floating");
  a_edge: assert property (p_edge)
    else $error("edge select bit clear");
  a_hold: assert property (p_hold)
    else $error("hold bit not one clock");
  a_dflt: assert property (p_dflt)
    else $error("bad config after reset");
  a_freeze: assert property (p_freeze)
    else $error("moved while frozen");
  a_ready: assert property (p_ready)
    else $error("array held off after start");
endmodule : burst_ctrl_asserts

// >>> test/host_model.sv
`timescale 1ns/1ps
// ------------------------------
// Host controller: strobes a start, captures words
// ------------------------------
module host_model (
  // Clock and data lines
  input wire logic clk_i,
  input wire logic [31:0] data_i,
  input wire logic valid_i,
  // Strobes and address
  output logic ce_n_o,
  output logic adv_n_o,
  output logic [23:0] addr_o
);
  logic [31:0] words[$];
  initial begin
    ce_n_o = 1'b1;
    adv_n_o = 1'b1;
    addr_o = 24'h0;
  end
  // One word taken per rising edge that shows valid
  always @(posedge clk_i) begin
    if (valid_i === 1'b1) begin
      words.push_back(data_i);
    end
  end
  // Strobe low for one edge; the address is junk once it is released
  task automatic start(input logic [23:0] a);
    @(posedge clk_i);
    #1;
    ce_n_o <= 1'b0;
    adv_n_o <= 1'b0;
    addr_o <= a;
    words.delete();
    @(posedge clk_i);
    #1;
    adv_n_o <= 1'b1;
    addr_o <= ~a;
  endtask : start
  // Strobe pulsed while deselected; its rise with chip enable starts
  task automatic start_rise(input logic [23:0] a);
    @(posedge clk_i);
    #1;
    adv_n_o <= 1'b0;
    addr_o <= a;
    words.delete();
    @(posedge clk_i);
    #1;
    ce_n_o <= 1'b0;
    adv_n_o <= 1'b1;
    @(posedge clk_i);
    #1;
    addr_o <= ~a;
  endtask : start_rise
  task automatic stop();
    @(posedge clk_i);
    #1;
    ce_n_o <= 1'b1;
  endtask : stop
endmodule : host_model

// >>> test/burst_read_initial_delay_ctrl_tb.sv
`timescale 1ns/1ps
`include "burst_delay_map.svh"
module burst_read_initial_delay_ctrl_tb;
  import burst_delay_pkg::*;
  logic clk, rst_n, clk_en, reg_wr, reg_rd, ce_n, adv_n, oe_n, dvalid;
  logic arr_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, data, arr_data;
  logic [23:0] addr;
  state_t state;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // ------------------------------
  // Device and host
  // ------------------------------
  burst_read_initial_delay_ctrl burst_read_initial_delay_ctrl_i (
    .CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(clk_en),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .CHIP_EN_N_I(ce_n),
    .ADDRESS_VALID_STROBE_N_I(adv_n), .ADDR_I(addr), .DATA_LINES_O(data),
    .DATA_LINES_OE_N_O(oe_n), .DATA_VALID_O(dvalid), .ARRAY_REQ_O(),
    .ARRAY_ADDR_O(), .ARRAY_DATA_I(arr_data), .ARRAY_VALID_I(arr_valid),
    .ARRAY_READY_O(), .BURST_STATE_O(state));
  host_model host_model_i (.clk_i(clk), .data_i(data), .valid_i(dvalid),
    .ce_n_o(ce_n), .adv_n_o(adv_n), .addr_o(addr));
  // Free-running clock and a hang guard well above the expected run
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  // Outputs are read 1 ns after the edge, once its updates have landed
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick();
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    tick();
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    d = reg_rdata;
  endtask : rd
  function automatic logic [31:0] cfg(input logic rm, input logic [3:0] f);
    return {16'h0, rm, 1'b0, f, 3'h0, `EDGE_RISING, 6'h0};
  endfunction : cfg
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rd(`CFG_OFS, d);
    check(d, cfg(1'b1, `DELAY_RST));
    rd(8'h20, d);
    check(d, 32'h0);
    wr(`CFG_OFS, 32'h0000_9e00);
    rd(`CFG_OFS, d);
    check(d, cfg(1'b1, `DELAY_RST));
    wr(`CFG_OFS, cfg(1'b1, 4'h2));
    wr(`CFG_OFS, 32'h0000_2400);
    rd(`CFG_OFS, d);
    check(d, cfg(1'b0, 4'h2));
  endtask : t_regs
  // Two words fetched; field 3 starts on a strobe rise, field 4 freezes
  // two edges mid delay
  task automatic t_read(input logic rm, input logic [3:0] f);
    int m;
    int n;
    logic [31:0] w;
    w = 32'h5a5a_0000 | {28'h0, f};
    n = rm ? 2 : f + 2;
    if (!rm && f == 4'h4) n = n + 2;
    wr(`CFG_OFS, cfg(rm, f));
    if (f == 4'h3) begin
      host_model_i.start_rise({20'h0, f});
    end else begin
      host_model_i.start({20'h0, f});
    end
    arr_data <= w;
    arr_valid <= 1'b1;
    m = 0;
    while (m < 20 && dvalid !== 1'b1) begin
      tick();
      m++;
      arr_data <= w + 32'h1;
      if (m == 2) arr_valid <= 1'b0;
      if (n > f + 2 && m inside {2, 4}) clk_en <= (m == 4);
    end
    check(32'(m), 32'(n));
    check(data, w);
    tick();
    check({31'h0, dvalid}, 32'h1);
    check(data, rm ? w : w + 32'h1);
    tick();
    check({31'h0, dvalid}, {31'h0, rm});
    check(32'(host_model_i.words.size()), 32'h2);
    check(host_model_i.words[0], w);
    host_model_i.stop();
    tick();
    check({31'h0, oe_n}, 32'h1);
    check({30'h0, state}, {30'h0, ST_IDLE});
  endtask : t_read
  task automatic t_reset_mid();
    logic [31:0] d;
    wr(`CFG_OFS, cfg(1'b0, 4'h0));
    host_model_i.start(24'h00_0123);
    arr_valid <= 1'b1;
    tick(2);
    arr_valid <= 1'b0;
    check({31'h0, oe_n}, 32'h0);
    rst_n <= 1'b0;
    tick(2);
    check({30'h0, state}, {30'h0, ST_IDLE});
    check({31'h0, oe_n}, 32'h1);
    check({31'h0, dvalid}, 32'h0);
    rst_n <= 1'b1;
    rd(`CFG_OFS, d);
    check(d, cfg(1'b1, `DELAY_RST));
    host_model_i.stop();
  endtask : t_reset_mid
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    arr_data = 32'h0;
    arr_valid = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    for (int f = 0; f < 8; f++) t_read(1'b0, 4'(f));
    t_read(1'b1, 4'h7);
    t_reset_mid();
    wrap_up();
  end
endmodule : burst_read_initial_delay_ctrl_tb
bind burst_read_initial_delay_ctrl burst_ctrl_asserts #(.AW(AW))
  burst_ctrl_asserts_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .CLK_EN_I(CLK_EN_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .CHIP_EN_N_I(CHIP_EN_N_I),
  .ADDRESS_VALID_STROBE_N_I(ADDRESS_VALID_STROBE_N_I), .ADDR_I(ADDR_I),
  .DATA_LINES_OE_N_O(DATA_LINES_OE_N_O), .DATA_VALID_O(DATA_VALID_O),
  .ARRAY_REQ_O(ARRAY_REQ_O), .ARRAY_ADDR_O(ARRAY_ADDR_O),
  .ARRAY_READY_O(ARRAY_READY_O), .BURST_STATE_O(BURST_STATE_O));
